/* File: hw/dagt_regs.sv */
/*
  Control and status register bank of a dual-channel converter: current
  scales, temperature readout, alert suppression and sticky event status.
  Assumes a decoded byte register port, events synchronous to CORE_CLK_I.
*/
// Contract
// - First channel scale bits 7:4, reset ones
// - Second channel scale bits 3:0, reset ones
// - Temperature readout: read-only two's complement byte
// - Suppression field bits 6:0, reset zero
// - Suppressed events do not drive alert pin
// - Suppression bit one means suppressed
// - Suppressed events still recorded in status
// - Zero write pointer sets status bit 6
// - Zero write pointer stuck until next sync
// - Pointer collision sets status bit 5
// - Pattern mismatch sets status bit 3
// - Pointers two apart set status bit 1
// - Pointers one apart set status bit 0
// - Status resets zero, host write clears it
// - Alert polarity selects active low or high
// - Auto-clear after 64 consecutive good samples; here cycles without a good sample hold the count, events or a low auto-clear enable restart it
// - Near-pointer events need their enable bits
`timescale 1ns/100ps
`default_nettype none
module dagt_regs
  import dagt_pkg::*;
(
  // Clock and reset
  input  wire logic                                CORE_CLK_I,
  input  wire logic                                SRST_I,
  // Register access port
  input  wire logic                                REG_WR_I,
  input  wire logic                                REG_RD_I,
  input  wire logic [dagt_pkg::REG_ADDR_W-1:0]     REG_ADDR_I,
  input  wire logic [dagt_pkg::REG_DATA_W-1:0]     REG_WDATA_I,
  output var  logic [dagt_pkg::REG_DATA_W-1:0]     REG_RDATA_O,
  // Control bits kept elsewhere in the map
  input  wire logic                                ALERT_POLARITY_I,
  input  wire logic                                AUTO_CLEAR_ENABLE_I,
  input  wire logic                                TWO_APART_REPORT_ENABLE_I,
  input  wire logic                                ONE_APART_REPORT_ENABLE_I,
  // FIFO and checker event sources
  input  wire logic                                WPTR_ADVANCE_I,
  input  wire logic                                WPTR_SYNC_I,
  input  wire logic [dagt_pkg::WPTR_W-1:0]         WPTR_LOAD_I,
  input  wire logic                                POINTER_COLLISION_I,
  input  wire logic                                PATTERN_MISMATCH_I,
  input  wire logic                                POINTERS_TWO_APART_I,
  input  wire logic                                POINTERS_ONE_APART_I,
  input  wire logic                                GOOD_SAMPLE_I,
  // Temperature sensor
  input  wire logic [7:0]                          TEMP_SENSOR_I,
  // Outputs to the analog side and pins
  output var  logic [dagt_pkg::SCALE_W-1:0]        FIRST_CHANNEL_SCALE_O,
  output var  logic [dagt_pkg::SCALE_W-1:0]        SECOND_CHANNEL_SCALE_O,
  output var  logic [dagt_pkg::WPTR_W-1:0]         WPTR_O,
  output var  logic                                ALERT_OUTPUT_PIN_O
);
  // Whole module state
  typedef struct packed {
    logic [7:0]            scale;     // Both channel scales
    logic [SUPPR_W-1:0]    suppr;     // Alert suppression mask
    logic [7:0]            status;    // Sticky event status
    logic [7:0]            temp;      // Sampled temperature
    logic [7:0]            rdata;     // Read data
    logic                  alert;     // Alert pin level
    logic [GOOD_CNT_W-1:0] good_cnt;  // Good samples since last event
    logic [WPTR_W-1:0]     wptr;      // Pointer copy for output
  } dagt_state_s;

  dagt_state_s st;       // Registered state
  dagt_state_s next_st;  // Next state

  dagt_ptr_if pif ();  // Pointer carrier

  // Write pointer tracker
  dagt_wptr u_wptr (
    .core_clk_i (CORE_CLK_I),
    .srst_i     (SRST_I),
    .pif        (pif.tracker)
  );

  assign pif.advance  = WPTR_ADVANCE_I;
  assign pif.sync     = WPTR_SYNC_I;
  assign pif.load_val = WPTR_LOAD_I;

  // Register address match
  function automatic logic hit(input logic [REG_ADDR_W-1:0] addr, input logic [4:0] ofs);
    hit = (addr == ofs);
  endfunction

  logic [7:0] events;      // Events seen this cycle
  logic       status_wr;   // Host write to status
  logic       auto_clr;    // Auto-clear fires this cycle
  logic       alert_act;   // Any unsuppressed recorded event

  // Event vector, reserved bits kept zero
  always_comb
  begin
    events                = 8'h00;
    events[EVT_PTR_ZERO]  = pif.is_zero;
    events[EVT_COLLISION] = POINTER_COLLISION_I;
    events[EVT_PATTERN]   = PATTERN_MISMATCH_I;
    events[EVT_TWO_APART] = POINTERS_TWO_APART_I && TWO_APART_REPORT_ENABLE_I;
    events[EVT_ONE_APART] = POINTERS_ONE_APART_I && ONE_APART_REPORT_ENABLE_I;
  end

  assign status_wr = REG_WR_I && hit(REG_ADDR_I, OFS_EVENT_STATUS);
  assign auto_clr  = AUTO_CLEAR_ENABLE_I && GOOD_SAMPLE_I && (events == 8'h00)
                     && (st.good_cnt == GOOD_CNT_W'(AUTO_CLEAR_SAMPLES - 1));
  // Suppression bit one blocks the event from the pin
  assign alert_act = |(st.status[SUPPR_W-1:0] & ~st.suppr);

  // Next state
  always_comb
  begin
    next_st = st;
    // Temperature sampled every cycle, never written by the host
    next_st.temp = TEMP_SENSOR_I;
    next_st.wptr = pif.ptr;
    // Host writes
    if (REG_WR_I && hit(REG_ADDR_I, OFS_CURRENT_SCALE))
    begin
      next_st.scale = REG_WDATA_I;
    end
    if (REG_WR_I && hit(REG_ADDR_I, OFS_ALERT_SUPPR))
    begin
      next_st.suppr = REG_WDATA_I[SUPPR_W-1:0];
    end
    // Good sample counter, restarted by any event
    if (!AUTO_CLEAR_ENABLE_I || (events != 8'h00))
    begin
      next_st.good_cnt = '0;
    end
    else if (GOOD_SAMPLE_I)
    begin
      if (auto_clr)
        next_st.good_cnt = '0;
      else
        next_st.good_cnt = st.good_cnt + GOOD_CNT_W'(1);
    end
    // Sticky status: set wins over clear, suppression does not stop it
    if (status_wr || auto_clr)
    begin
      next_st.status = events;
    end
    else
    begin
      next_st.status = st.status | events;
    end
    // Registered read data, unmapped offsets read zero
    if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        OFS_CURRENT_SCALE: next_st.rdata = st.scale;
        OFS_TEMPERATURE:   next_st.rdata = st.temp;
        OFS_ALERT_SUPPR:   next_st.rdata = {1'b0, st.suppr};
        OFS_EVENT_STATUS:  next_st.rdata = st.status & EVT_USED_MASK;
        default:           next_st.rdata = 8'h00;
      endcase
    end
    // Pin level from polarity: zero active low, one active high
    next_st.alert = alert_act ~^ ALERT_POLARITY_I;
  end

  // State register
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      st          <= '0;
      st.scale    <= RST_CURRENT_SCALE;
      st.suppr    <= RST_ALERT_SUPPR;
      st.status   <= RST_EVENT_STATUS;
      st.temp     <= RST_TEMPERATURE;
      st.alert    <= 1'b1;
      st.wptr     <= RST_WPTR;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign FIRST_CHANNEL_SCALE_O  = st.scale[FLD_FIRST_SCALE_LSB +: SCALE_W];
  assign SECOND_CHANNEL_SCALE_O = st.scale[FLD_SECOND_SCALE_LSB +: SCALE_W];
  assign REG_RDATA_O            = st.rdata;
  assign ALERT_OUTPUT_PIN_O     = st.alert;
  assign WPTR_O                 = st.wptr;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);

  // Host write to status register
  sequence s_status_write;
    REG_WR_I && (REG_ADDR_I == OFS_EVENT_STATUS);
  endsequence
  // Quiet cycle: no event source active
  sequence s_quiet;
    (events == 8'h00);
  endsequence

  property p_scale_reset;
    $fell(SRST_I) |-> (FIRST_CHANNEL_SCALE_O == 4'hf) && (SECOND_CHANNEL_SCALE_O == 4'hf);
  endproperty
  a_scale_reset: assert property (p_scale_reset) else $error("Scales not full after reset");

  property p_scale_write;
    REG_WR_I && (REG_ADDR_I == OFS_CURRENT_SCALE) |=>
      (FIRST_CHANNEL_SCALE_O == $past(REG_WDATA_I[7:4])) && (SECOND_CHANNEL_SCALE_O == $past(REG_WDATA_I[3:0]));
  endproperty
  a_scale_write: assert property (p_scale_write) else $error("Scale write not applied");

  property p_temp_read;
    REG_RD_I && (REG_ADDR_I == OFS_TEMPERATURE) && !$past(SRST_I) |=> (REG_RDATA_O == $past(TEMP_SENSOR_I, 2));
  endproperty
  a_temp_read: assert property (p_temp_read) else $error("Temperature read mismatch");

  property p_suppr_write;
    REG_WR_I && (REG_ADDR_I == OFS_ALERT_SUPPR) ##1 REG_RD_I && (REG_ADDR_I == OFS_ALERT_SUPPR) && !REG_WR_I
      |=> (REG_RDATA_O == {1'b0, $past(REG_WDATA_I[6:0], 2)});
  endproperty
  a_suppr_write: assert property (p_suppr_write) else $error("Suppression read back wrong");

  property p_alert_pin;
    1'b1 |=> (ALERT_OUTPUT_PIN_O == ($past(|(st.status[6:0] & ~st.suppr)) ~^ $past(ALERT_POLARITY_I)));
  endproperty
  a_alert_pin: assert property (p_alert_pin) else $error("Alert pin level wrong");

  property p_masked_recorded;
    PATTERN_MISMATCH_I && st.suppr[EVT_PATTERN] |=> st.status[EVT_PATTERN];
  endproperty
  a_masked_recorded: assert property (p_masked_recorded) else $error("Suppressed event not recorded");

  property p_zero_ptr;
    pif.is_zero |=> st.status[EVT_PTR_ZERO];
  endproperty
  a_zero_ptr: assert property (p_zero_ptr) else $error("Zero pointer not recorded");

  property p_collision;
    POINTER_COLLISION_I |=> st.status[EVT_COLLISION];
  endproperty
  a_collision: assert property (p_collision) else $error("Collision not recorded");

  property p_two_gated;
    $rose(st.status[EVT_TWO_APART]) |-> $past(POINTERS_TWO_APART_I && TWO_APART_REPORT_ENABLE_I);
  endproperty
  a_two_gated: assert property (p_two_gated) else $error("Two-apart set without enable");

  property p_one_gated;
    $rose(st.status[EVT_ONE_APART]) |-> $past(POINTERS_ONE_APART_I && ONE_APART_REPORT_ENABLE_I);
  endproperty
  a_one_gated: assert property (p_one_gated) else $error("One-apart set without enable");

  property p_status_clear;
    s_status_write and s_quiet |=> (st.status == 8'h00);
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("Status write did not clear");

  property p_sticky;
    st.status[EVT_COLLISION] && !status_wr && !auto_clr |=> st.status[EVT_COLLISION];
  endproperty
  a_sticky: assert property (p_sticky) else $error("Status bit dropped without clear");

  property p_good_cnt_bound;
    1'b1 |-> (st.good_cnt < GOOD_CNT_W'(AUTO_CLEAR_SAMPLES));
  endproperty
  a_good_cnt_bound: assert property (p_good_cnt_bound) else $error("Good sample count overran");

  property p_auto_clear;
    auto_clr |=> (st.status == $past(events));
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("Auto-clear did not clear status");

  // Pattern mismatch recorded at the next edge
  property p_pattern;
    PATTERN_MISMATCH_I |=> st.status[EVT_PATTERN];
  endproperty
  a_pattern: assert property (p_pattern) else $error("Pattern mismatch not recorded");

  // Enabled two-apart event recorded at the next edge
  property p_two_apart;
    POINTERS_TWO_APART_I && TWO_APART_REPORT_ENABLE_I |=> st.status[EVT_TWO_APART];
  endproperty
  a_two_apart: assert property (p_two_apart) else $error("Two-apart event not recorded");

  // Enabled one-apart event recorded at the next edge
  property p_one_apart;
    POINTERS_ONE_APART_I && ONE_APART_REPORT_ENABLE_I |=> st.status[EVT_ONE_APART];
  endproperty
  a_one_apart: assert property (p_one_apart) else $error("One-apart event not recorded");

  // Mask and status back at zero when reset lets go
  property p_mask_status_reset;
    $fell(SRST_I) |-> (st.suppr == RST_ALERT_SUPPR) && (st.status == RST_EVENT_STATUS);
  endproperty
  a_mask_status_reset: assert property (p_mask_status_reset) else $error("Mask or status not zero after reset");

  // A zero pointer shows on the pointer output one cycle later
  property p_zero_ptr_out;
    pif.is_zero |=> (WPTR_O == 8'h00);
  endproperty
  a_zero_ptr_out: assert property (p_zero_ptr_out) else $error("Zero pointer not shown on output");
endmodule
`default_nettype wire

/* File: hw/dagt_pkg.sv */
/*
  Constants shared by the converter control/status register bank:
  register offsets, field positions, reset values and counts.
  Assumes a decoded single-byte register access port in front of it.
*/
`default_nettype none
package dagt_pkg;
  // Register access widths
  localparam int unsigned REG_ADDR_W = 5;  // Register address width
  localparam int unsigned REG_DATA_W = 8;  // Register data width

  // Register offsets
  localparam logic [4:0] OFS_CURRENT_SCALE = 5'h04;  // Output current scale
  localparam logic [4:0] OFS_TEMPERATURE   = 5'h05;  // Temperature readout
  localparam logic [4:0] OFS_ALERT_SUPPR   = 5'h06;  // Alert suppression mask
  localparam logic [4:0] OFS_EVENT_STATUS  = 5'h07;  // Sticky event status

  // Reset values
  localparam logic [7:0] RST_CURRENT_SCALE = 8'hff;  // Both scales at full
  localparam logic [6:0] RST_ALERT_SUPPR   = 7'h00;  // Nothing suppressed
  localparam logic [7:0] RST_EVENT_STATUS  = 8'h00;  // No events recorded
  localparam logic [7:0] RST_TEMPERATURE   = 8'h00;  // Before first sample

  // Field positions
  localparam int unsigned FLD_FIRST_SCALE_LSB  = 4;  // First channel scale 7:4
  localparam int unsigned FLD_SECOND_SCALE_LSB = 0;  // Second channel scale 3:0
  localparam int unsigned SCALE_W              = 4;  // Scale field width
  localparam int unsigned SUPPR_W              = 7;  // Suppression field width

  // Event status bit positions
  localparam int unsigned EVT_PTR_ZERO  = 6;  // Write pointer all zeros
  localparam int unsigned EVT_COLLISION = 5;  // Pointer over/under run
  localparam int unsigned EVT_PATTERN   = 3;  // Pattern mismatch
  localparam int unsigned EVT_TWO_APART = 1;  // Pointers two apart
  localparam int unsigned EVT_ONE_APART = 0;  // Pointers one apart
  localparam logic [7:0]  EVT_USED_MASK = 8'h6b;  // Implemented status bits

  // Auto-clear sample count
  localparam int unsigned AUTO_CLEAR_SAMPLES = 64;  // Good samples before clear
  localparam int unsigned GOOD_CNT_W         = 7;   // Counter width

  // Write pointer
  localparam int unsigned WPTR_W   = 8;      // One-hot pointer width
  localparam logic [7:0]  RST_WPTR = 8'h01;  // Pointer after reset
endpackage
`default_nettype wire

/* File: hw/dagt_ptr_if.sv */
/*
  Carrier between the register bank and the FIFO write pointer tracker.
  Assumes both ends share CORE_CLK_I.
*/
`timescale 1ns/100ps
`default_nettype none
interface dagt_ptr_if;
  logic       advance;   // Step pointer by one slot
  logic       sync;      // Reload pointer
  logic [7:0] load_val;  // Value loaded on sync
  logic [7:0] ptr;       // Current one-hot pointer
  logic       is_zero;   // Pointer holds all zeros

  modport bank    (output advance, output sync, output load_val, input ptr, input is_zero);
  modport tracker (input advance, input sync, input load_val, output ptr, output is_zero);
endinterface
`default_nettype wire

/* File: hw/dagt_wptr.sv */
/*
  One-hot FIFO write pointer held as a rotating shift register.
  Assumes synchronous active-high reset and the pointer carrier interface.
*/
`timescale 1ns/100ps
`default_nettype none
module dagt_wptr
  import dagt_pkg::*;
(
  // Clock and reset
  input  wire logic   core_clk_i,
  input  wire logic   srst_i,
  // Pointer carrier
  dagt_ptr_if.tracker pif
);
  // Whole module state
  typedef struct packed {
    logic [WPTR_W-1:0] ptr;  // One-hot write pointer
  } dagt_wptr_s;

  dagt_wptr_s st;       // Registered state
  dagt_wptr_s next_st;  // Next state

  // Rotation keeps an all-zero pointer at zero, so it stays stuck until sync
  always_comb
  begin
    next_st = st;
    if (pif.sync)
    begin
      // Sync reloads the pointer
      next_st.ptr = pif.load_val;
    end
    else if (pif.advance)
    begin
      // Rotate one slot
      next_st.ptr = {st.ptr[WPTR_W-2:0], st.ptr[WPTR_W-1]};
    end
  end

  // State register
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      st <= '{ptr: RST_WPTR};
    else
      st <= next_st;
  end

  assign pif.ptr     = st.ptr;
  assign pif.is_zero = (st.ptr == '0);

  // Zero pointer stays zero until the next sync
  property p_ptr_stuck;
    @(posedge core_clk_i) disable iff (srst_i)
      (st.ptr == '0) && !pif.sync |=> (st.ptr == '0);
  endproperty
  a_ptr_stuck: assert property (p_ptr_stuck) else $error("Zero write pointer left stuck state");
endmodule
`default_nettype wire

/* File: verification/dagt_host_model.sv */
/*
  Host model on the decoded register port: single-byte writes and reads.
  Assumes strobes are sampled on the rising edge of the core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module dagt_host_model
(
  // Clock
  input  wire logic                            clk_i,
  // Register port
  output var  logic                            wr_o,
  output var  logic                            rd_o,
  output var  logic [dagt_pkg::REG_ADDR_W-1:0] addr_o,
  output var  logic [dagt_pkg::REG_DATA_W-1:0] wdata_o,
  input  wire logic [dagt_pkg::REG_DATA_W-1:0] rdata_i
);
  import dagt_pkg::*;

  // Idle bus at time zero
  initial
  begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = 5'h00;
    wdata_o = 8'h00;
  end

  // One write, held through its sampling edge, then released
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o    = 1'b1;
    addr_o  = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o    = 1'b0;
    addr_o  = ~a;  // Released lines do not keep the last value
    wdata_o = ~d;
  endtask

  // Write then read back in the next cycle; the strobe passes from write to read without a gap
  task automatic wr_rd(input logic [4:0] a, input logic [7:0] wd, output logic [7:0] d);
    @(negedge clk_i);
    wr_o    = 1'b1;
    addr_o  = a;
    wdata_o = wd;
    @(negedge clk_i);
    wr_o    = 1'b0;
    rd_o    = 1'b1;
    @(negedge clk_i);
    rd_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~wd;
    d       = rdata_i;  // Registered answer of the read edge
  endtask

  // One read; strobes at least a cycle apart, a slow pace for the sensor
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk_i);
    rd_o   = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    rd_o   = 1'b0;
    addr_o = ~a;
    d      = rdata_i;  // Registered answer, settled after the read edge
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_dac_alarm_gain_temp_regs.sv */
/*
  Self-checking bench of the converter control and status register bank.
  Assumes the host model for register traffic; events are driven here.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb_dac_alarm_gain_temp_regs;
  import dagt_pkg::*;
  logic       clk = 1'b0;    // Core clock
  logic       srst = 1'b1;   // Synchronous reset
  logic       pol = 1'b1;    // Alert polarity
  logic       ac = 1'b0;     // Auto-clear enable
  logic       en2 = 1'b1;    // Two-apart enable
  logic       en1 = 1'b1;    // One-apart enable
  logic       adv = 1'b0;    // Pointer advance
  logic       sync = 1'b0;   // Pointer reload
  logic [7:0] load = 8'h00;  // Reload value
  logic       coll = 1'b0;   // Event inputs
  logic       patt = 1'b0;
  logic       two = 1'b0;
  logic       one = 1'b0;
  logic       good = 1'b0;   // Good sample
  logic [7:0] temp = 8'h00;  // Sensor value
  logic       wr, rd;        // Host strobes
  logic [4:0] addr;
  logic [7:0] wdata, rdata, d, v;
  logic [3:0] s1, s2;        // Scale outputs
  logic [7:0] wptr;
  logic       alert;
  int         n_mismatch = 0;
  int         checks = 0;
  int         bits[5] = '{6, 5, 3, 1, 0};

  // Clock of 4 ns period
  always #2 clk = ~clk;

  // Random pointer stepping at the falling edge
  always @(negedge clk) adv <= 1'($urandom);

  dagt_host_model host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));

  dagt_regs DUT (
    .CORE_CLK_I(clk), .SRST_I(srst), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .ALERT_POLARITY_I(pol), .AUTO_CLEAR_ENABLE_I(ac),
    .TWO_APART_REPORT_ENABLE_I(en2), .ONE_APART_REPORT_ENABLE_I(en1), .WPTR_ADVANCE_I(adv),
    .WPTR_SYNC_I(sync), .WPTR_LOAD_I(load), .POINTER_COLLISION_I(coll), .PATTERN_MISMATCH_I(patt),
    .POINTERS_TWO_APART_I(two), .POINTERS_ONE_APART_I(one), .GOOD_SAMPLE_I(good),
    .TEMP_SENSOR_I(temp), .FIRST_CHANNEL_SCALE_O(s1), .SECOND_CHANNEL_SCALE_O(s2),
    .WPTR_O(wptr), .ALERT_OUTPUT_PIN_O(alert));

  // Expected alert level from polarity and whether an unmasked event stands
  function automatic logic pin_exp(input logic p, input logic act);
    return act ? p : ~p;
  endfunction

  // Raise one event source across a single sampling edge
  task automatic fire(input int b);
    @(negedge clk);
    case (b)
      6: sync = 1'b1;  // Reload with all zeros corrupts the pointer
      5: coll = 1'b1;
      3: patt = 1'b1;
      1: two = 1'b1;
      default: one = 1'b1;
    endcase
    @(negedge clk);
    {sync, coll, patt, two, one} = 5'h00;
  endtask

  // Fresh pointer sync after a zero pointer, then clear the status
  task automatic recover();
    @(negedge clk);
    load = 8'h01;
    sync = 1'b1;
    @(negedge clk);
    sync = 1'b0;
    load = 8'h00;
    host.wr(OFS_EVENT_STATUS, 8'($urandom));
  endtask

  // Closing report
  task automatic print_verdict();
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial
  begin
    #200000;
    n_mismatch++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'he4f8));
    repeat (5) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    // Reset values and an unmapped place
    host.rd(OFS_CURRENT_SCALE, d); `CHK("scale reset", 8'hff, d)
    host.rd(OFS_ALERT_SUPPR, d);   `CHK("suppr reset", 8'h00, d)
    host.rd(OFS_EVENT_STATUS, d);  `CHK("status reset", 8'h00, d)
    host.wr(5'h1f, 8'ha5);
    host.rd(5'h1f, d);             `CHK("unmapped", 8'h00, d)
    // Random scales, starting with 8'h00 and 8'h0f
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h0f : 8'($urandom);
      host.wr(OFS_CURRENT_SCALE, v);
      `CHK("first scale", v[7:4], s1)
      `CHK("second scale", v[3:0], s2)
      host.rd(OFS_CURRENT_SCALE, d); `CHK("scale read", v, d)
    end
    // Temperature readout, read-only
    for (int i = 0; i < 4; i++)
    begin
      temp = (i == 0) ? 8'hd8 : 8'($urandom);
      host.wr(OFS_TEMPERATURE, ~temp);
      host.rd(OFS_TEMPERATURE, d); `CHK("temperature", temp, d)
    end
    // Suppression mask, bit 7 unused
    v = 8'($urandom) | 8'h80;
    host.wr_rd(OFS_ALERT_SUPPR, v, d); `CHK("suppr read", v & 8'h7f, d)
    // Every event source, unmasked then masked, random polarity
    foreach (bits[k])
    begin
      for (int m = 0; m < 2; m++)
      begin
        pol = 1'($urandom);
        host.wr(OFS_ALERT_SUPPR, m ? 8'(1 << bits[k]) : 8'h00);
        host.wr(OFS_EVENT_STATUS, 8'h00);
        fire(bits[k]);
        repeat (3) @(negedge clk);
        `CHK("alert pin", pin_exp(pol, m == 0), alert)
        host.rd(OFS_EVENT_STATUS, d);
        `CHK("status sticky", 8'(1 << bits[k]), d)
        if (bits[k] == 6)
        begin
          `CHK("stuck pointer", 8'h00, wptr)
          recover();
          `CHK("pointer one-hot", 1'b1, 1'($onehot(wptr)))
        end
        host.wr(OFS_EVENT_STATUS, 8'($urandom));
        host.rd(OFS_EVENT_STATUS, d); `CHK("status cleared", 8'h00, d)
        `CHK("alert idle", pin_exp(pol, 1'b0), alert)
      end
    end
    // Near-pointer events ignored while their enables are low
    en1 = 1'b0;
    en2 = 1'b0;
    fire(1);
    fire(0);
    host.rd(OFS_EVENT_STATUS, d);  `CHK("gated events", 8'h00, d)
    en1 = 1'b1;
    en2 = 1'b1;
    // Auto-clear: 63 good samples keep the event, 64 clear it
    ac = 1'b1;
    for (int n = 63; n <= 64; n++)
    begin
      fire(3);
      good = 1'b1;
      repeat (n) @(negedge clk);
      good = 1'b0;
      host.rd(OFS_EVENT_STATUS, d);
      `CHK("auto clear", (n == 64) ? 8'h00 : 8'h08, d)
    end
    ac = 1'b0;
    print_verdict();
  end
endmodule
`default_nettype wire
